// File: conversion_mode_cfg.v
// Summary of operation
// - The rate-and-filter register sits at index 0x02 and resets to 0x24.
// - Bits 7 to 3 of that register hold the read/write rate code, reset 00100.
// - Rate codes 00000 to 01111 pick 2.5 up to 25600 samples per second, 20 by default.
// - Rate codes 10000 to 11111 all pick 40000 samples per second at a 10.24 MHz clock.
// - Bits 2 to 0 pick sinc1, sinc2, sinc3, sinc4 or FIR, reset FIR, codes 101 to 111 reserved.
// - The conversion-control register sits at index 0x03, resets to 0x01, and bit 7 is kept zero.
// - Bits 6 to 5 pick normal, chop, two-wire or four-wire excitation, the latter two on the larger part only.
// - Bit 4 picks continuous conversions when clear and a single conversion when set.
// - Bits 3 to 0 set the start wait, referenced to 7.3728 MHz, reset 0001.
// - Wait codes 0000 to 1101 map to 0 us up to 17.8 ms; 1110 and 1111 are reserved.
// - The auxiliary-pin register sits at index 0x04, resets to 0x00, link bits high, direction bits low.
// - A set link bit joins auxiliary pin n to its analog input, pin 3 on input five down to pin 0 on input two.
// - A clear direction bit makes the pin an output, a set one makes it an input.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_mode_defs.vh"

module conversion_mode_cfg #(
	parameter HAS_EXCITATION = 1
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        conv_clk_pin,
	input  wire        start_req,
	input  wire        stop_req,
	input  wire        conv_done,
	output wire [4:0]  output_rate_code,
	output reg  [18:0] rate_decisps,
	output reg         rate_is_top,
	output wire [2:0]  filter_code,
	output reg  [4:0]  filter_onehot,
	output wire [1:0]  op_mode,
	output reg         chop_en,
	output reg         ac_excite_en,
	output reg         ac_four_wire,
	output wire        one_shot_select,
	output wire [3:0]  start_wait_code,
	output wire        wait_active,
	output wire        conv_run,
	output wire        conv_idle,
	output wire        cfg_fault,
	output wire [3:0]  aux_pin_link,
	output wire [3:0]  aux_pin_dir_input,
	output wire [3:0]  aux_pin_oe
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_RUN  = 2'h2;

	reg  [7:0]  rate_filter_q;
	reg  [7:0]  conversion_ctrl_q;
	reg  [7:0]  aux_pin_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         wr_pend_q;
	reg         rd_pend_q;
	reg  [5:0]  idx_q;
	reg         mapped_q;
	reg         word_q;
	reg         filt_rsvd;
	reg         wait_rsvd;
	reg         zero_wait_fast;
	reg  [7:0]  ctrl_wr;
	reg  [31:0] rd_word;
	wire        addr_phase;
	wire [5:0]  idx_in;
	wire        mapped_in;
	wire        wait_start;
	wire        wait_done;
	wire        wait_busy;
	wire        do_write;
	wire [7:0]  status_word;
	reg         wait_active_q;
	reg         conv_run_q;
	reg         conv_idle_q;
	reg         cfg_fault_q;
	genvar      pin;

	// Tenths of samples per second for a rate code
	function [18:0] rate_lookup;
		input [4:0] code;
		begin
			case (code)
				5'h00: rate_lookup = 19'd25;
				5'h01: rate_lookup = 19'd50;
				5'h02: rate_lookup = 19'd100;
				5'h03: rate_lookup = 19'd166;
				5'h04: rate_lookup = 19'd200;
				5'h05: rate_lookup = 19'd500;
				5'h06: rate_lookup = 19'd600;
				5'h07: rate_lookup = 19'd1000;
				5'h08: rate_lookup = 19'd4000;
				5'h09: rate_lookup = 19'd12000;
				5'h0a: rate_lookup = 19'd24000;
				5'h0b: rate_lookup = 19'd48000;
				5'h0c: rate_lookup = 19'd72000;
				5'h0d: rate_lookup = 19'd144000;
				5'h0e: rate_lookup = 19'd192000;
				5'h0f: rate_lookup = 19'd256000;
				default: rate_lookup = 19'd400000;
			endcase
		end
	endfunction

	// Index is mapped when it names one of the registers
	function idx_mapped;
		input [5:0] idx;
		begin
			case (idx)
				`IDX_RATE_FILTER: idx_mapped = 1'b1;
				`IDX_CONV_CTRL:   idx_mapped = 1'b1;
				`IDX_AUX_PIN:     idx_mapped = 1'b1;
				`IDX_SEQ_STATUS:  idx_mapped = 1'b1;
				default:          idx_mapped = 1'b0;
			endcase
		end
	endfunction

	// Operating mode compare, shared by the mode decodes
	function mode_is;
		input [1:0] mode;
		input [1:0] code;
		begin
			mode_is = (mode == code);
		end
	endfunction

	// AHB-Lite slave: writes take no wait state, reads take one
	assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
	assign idx_in     = haddr[7:2];
	assign mapped_in  = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && idx_mapped(idx_in);
	assign hreadyout  = ~rd_pend_q;
	assign hresp      = `HRESP_OKAY;
	assign do_write   = wr_pend_q & mapped_q & word_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			idx_q     <= 6'h00;
			mapped_q  <= 1'b0;
			word_q    <= 1'b0;
		end else begin
			rd_pend_q <= 1'b0;
			if (hready) begin
				wr_pend_q <= addr_phase & hwrite;
				rd_pend_q <= addr_phase & ~hwrite;
			end else begin
				wr_pend_q <= 1'b0;
			end
			if (addr_phase) begin
				idx_q    <= idx_in;
				mapped_q <= mapped_in;
				word_q   <= (hsize == `HSIZE_WORD);
			end
		end
	end

	// Excitation codes are dropped on the smaller part
	always @* begin
		ctrl_wr = hwdata[7:0];
		ctrl_wr[`CTRL_RSVD_BIT] = 1'b0;
		if ((HAS_EXCITATION == 0) && hwdata[`OPMODE_MSB]) begin
			ctrl_wr[`OPMODE_MSB:`OPMODE_LSB] = conversion_ctrl_q[`OPMODE_MSB:`OPMODE_LSB];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_filter_q     <= `RST_RATE_FILTER;
			conversion_ctrl_q <= `RST_CONV_CTRL;
			aux_pin_q         <= `RST_AUX_PIN;
		end else if (do_write) begin
			case (idx_q)
				`IDX_RATE_FILTER: rate_filter_q <= hwdata[7:0];
				`IDX_CONV_CTRL:   conversion_ctrl_q <= ctrl_wr;
				`IDX_AUX_PIN:     aux_pin_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Status: fault flags, timer busy and sequencer state
	assign status_word = {2'h0, zero_wait_fast, wait_rsvd, filt_rsvd, wait_busy, state_q};

	always @* begin
		rd_word = 32'h00000000;
		case (idx_q)
			`IDX_RATE_FILTER: rd_word[7:0] = rate_filter_q;
			`IDX_CONV_CTRL:   rd_word[7:0] = conversion_ctrl_q;
			`IDX_AUX_PIN:     rd_word[7:0] = aux_pin_q;
			`IDX_SEQ_STATUS:  rd_word[7:0] = status_word;
			default:          rd_word = 32'h00000000;
		endcase
	end

	// Read data is loaded in the wait state and held until the next read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_q) begin
			hrdata <= mapped_q ? rd_word : 32'h00000000;
		end
	end

	// Field outputs
	assign output_rate_code  = rate_filter_q[`RATE_MSB:`RATE_LSB];
	assign filter_code       = rate_filter_q[`FILT_MSB:`FILT_LSB];
	assign op_mode           = conversion_ctrl_q[`OPMODE_MSB:`OPMODE_LSB];
	assign one_shot_select   = conversion_ctrl_q[`ONE_SHOT_BIT];
	assign start_wait_code   = conversion_ctrl_q[`WAIT_MSB:`WAIT_LSB];

	// One slice per auxiliary pin; the pin is driven while its direction bit is clear
	generate
		for (pin = 0; pin < `AUX_PIN_COUNT; pin = pin + 1) begin : g_aux_pin
			assign aux_pin_link[pin]      = aux_pin_q[`LINK_LSB + pin];
			assign aux_pin_dir_input[pin] = aux_pin_q[`DIR_LSB + pin];
			assign aux_pin_oe[pin]        = ~aux_pin_q[`DIR_LSB + pin];
		end
	endgenerate

	// Decoded configuration, registered for the conversion engine
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_decisps  <= `RST_RATE_DECISPS;
			rate_is_top   <= 1'b0;
			filter_onehot <= `RST_FILTER_ONEHOT;
			chop_en       <= 1'b0;
			ac_excite_en  <= 1'b0;
			ac_four_wire  <= 1'b0;
		end else begin
			rate_decisps <= rate_lookup(output_rate_code);
			rate_is_top  <= (output_rate_code >= `RATE_TOP_FIRST);
			case (filter_code)
				`FILT_SINC1: filter_onehot <= 5'h01;
				`FILT_SINC2: filter_onehot <= 5'h02;
				`FILT_SINC3: filter_onehot <= 5'h04;
				`FILT_SINC4: filter_onehot <= 5'h08;
				`FILT_FIR:   filter_onehot <= 5'h10;
				default:     filter_onehot <= 5'h00;
			endcase
			chop_en      <= mode_is(op_mode, `OPMODE_CHOP);
			ac_excite_en <= mode_is(op_mode, `OPMODE_AC2) || mode_is(op_mode, `OPMODE_AC4);
			ac_four_wire <= mode_is(op_mode, `OPMODE_AC4);
		end
	end

	// Settings that software should avoid are flagged, not blocked
	always @* begin
		filt_rsvd      = (filter_code > `FILT_FIR);
		wait_rsvd      = (start_wait_code > `WAIT_LAST_VALID);
		zero_wait_fast = (start_wait_code == `WAIT_ZERO) &&
		                 (output_rate_code >= `RATE_25600);
	end

	// Fault output comes from a flop, one cycle after the register change
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_fault_q <= 1'b0;
		end else begin
			cfg_fault_q <= filt_rsvd | wait_rsvd | zero_wait_fast;
		end
	end
	assign cfg_fault = cfg_fault_q;

	// Conversion sequencer: every conversion start goes through the wait
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_req) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (stop_req) begin
					state_d = ST_IDLE;
				end else if (wait_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop_req) begin
					state_d = ST_IDLE;
				end else if (conv_done) begin
					if (one_shot_select) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_WAIT;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign wait_start  = (state_d == ST_WAIT) && (state_q != ST_WAIT);

	// Loaded from the next state, so these flops stay in step with state_q
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_active_q <= 1'b0;
			conv_run_q    <= 1'b0;
			conv_idle_q   <= 1'b1;
		end else begin
			wait_active_q <= (state_d == ST_WAIT);
			conv_run_q    <= (state_d == ST_RUN);
			conv_idle_q   <= (state_d == ST_IDLE);
		end
	end
	assign wait_active = wait_active_q;
	assign conv_run    = conv_run_q;
	assign conv_idle   = conv_idle_q;

	start_wait_timer u_wait (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.conv_clk_pin (conv_clk_pin),
		.start        (wait_start),
		.wait_code    (start_wait_code),
		.busy         (wait_busy),
		.done         (wait_done)
	);

endmodule
`default_nettype wire

// File: adc_mode_defs.vh
`ifndef ADC_MODE_DEFS_VH
`define ADC_MODE_DEFS_VH

// Register indexes; byte address is four times the index
`define IDX_RATE_FILTER   6'h02
`define IDX_CONV_CTRL     6'h03
`define IDX_AUX_PIN       6'h04
`define IDX_SEQ_STATUS    6'h08

// Reset values
`define RST_RATE_FILTER   8'h24
`define RST_CONV_CTRL     8'h01
`define RST_AUX_PIN       8'h00
`define RST_RATE_DECISPS  19'd200
`define RST_FILTER_ONEHOT 5'h10

// Field positions
`define RATE_MSB          7
`define RATE_LSB          3
`define FILT_MSB          2
`define FILT_LSB          0
`define CTRL_RSVD_BIT     7
`define OPMODE_MSB        6
`define OPMODE_LSB        5
`define ONE_SHOT_BIT      4
`define WAIT_MSB          3
`define WAIT_LSB          0
`define LINK_MSB          7
`define LINK_LSB          4
`define DIR_MSB           3
`define DIR_LSB           0
`define AUX_PIN_COUNT     4

// Field encodings
`define FILT_SINC1        3'h0
`define FILT_SINC2        3'h1
`define FILT_SINC3        3'h2
`define FILT_SINC4        3'h3
`define FILT_FIR          3'h4
`define OPMODE_NORMAL     2'h0
`define OPMODE_CHOP       2'h1
`define OPMODE_AC2        2'h2
`define OPMODE_AC4        2'h3
`define RATE_25600        5'h0f
`define RATE_TOP_FIRST    5'h10
`define WAIT_ZERO         4'h0
`define WAIT_LAST_VALID   4'hd

// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD        3'h2
`define HRESP_OKAY        1'b0

// Start-wait times in ns, referenced to the converter clock below
`define CONV_CLK_HZ       64'd7372800
`define NS_PER_S          64'd1000000000
`define WAIT_T1_NS        64'd50000
`define WAIT_T2_NS        64'd59000
`define WAIT_T3_NS        64'd67000
`define WAIT_T4_NS        64'd85000
`define WAIT_T5_NS        64'd119000
`define WAIT_T6_NS        64'd189000
`define WAIT_T7_NS        64'd328000
`define WAIT_T8_NS        64'd605000
`define WAIT_T9_NS        64'd1160000
`define WAIT_T10_NS       64'd2270000
`define WAIT_T11_NS       64'd4490000
`define WAIT_T12_NS       64'd8930000
`define WAIT_T13_NS       64'd17800000
`define WAIT_CNT_W        18
// Converter clock cycles for a wait, rounded up
`define WAIT_CYC(t) ((((t) * `CONV_CLK_HZ) + `NS_PER_S - 64'd1) / `NS_PER_S)

`endif

// File: start_wait_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_mode_defs.vh"

module start_wait_timer (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        conv_clk_pin,
	input  wire        start,
	input  wire [3:0]  wait_code,
	output wire        busy,
	output reg         done
);

	reg                     sync1_q;
	reg                     sync2_q;
	reg                     sync3_q;
	reg                     busy_q;
	reg [`WAIT_CNT_W-1:0]   count_q;
	wire                    conv_edge;
	wire [63:0]             load_cyc;

	function [63:0] wait_cycles;
		input [3:0] code;
		begin
			case (code)
				4'h0: wait_cycles = 64'd0;
				4'h1: wait_cycles = `WAIT_CYC(`WAIT_T1_NS);
				4'h2: wait_cycles = `WAIT_CYC(`WAIT_T2_NS);
				4'h3: wait_cycles = `WAIT_CYC(`WAIT_T3_NS);
				4'h4: wait_cycles = `WAIT_CYC(`WAIT_T4_NS);
				4'h5: wait_cycles = `WAIT_CYC(`WAIT_T5_NS);
				4'h6: wait_cycles = `WAIT_CYC(`WAIT_T6_NS);
				4'h7: wait_cycles = `WAIT_CYC(`WAIT_T7_NS);
				4'h8: wait_cycles = `WAIT_CYC(`WAIT_T8_NS);
				4'h9: wait_cycles = `WAIT_CYC(`WAIT_T9_NS);
				4'ha: wait_cycles = `WAIT_CYC(`WAIT_T10_NS);
				4'hb: wait_cycles = `WAIT_CYC(`WAIT_T11_NS);
				4'hc: wait_cycles = `WAIT_CYC(`WAIT_T12_NS);
				// Reserved codes fall back to the longest wait
				default: wait_cycles = `WAIT_CYC(`WAIT_T13_NS);
			endcase
		end
	endfunction

	assign load_cyc  = wait_cycles(wait_code);
	assign conv_edge = sync2_q & ~sync3_q;
	assign busy      = busy_q;

	// Converter clock pin is sampled through two flops before use
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= conv_clk_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Wait counts converter clock edges, so it scales with that clock
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q  <= 1'b0;
			count_q <= {`WAIT_CNT_W{1'b0}};
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy_q  <= 1'b1;
				count_q <= load_cyc[`WAIT_CNT_W-1:0];
			end else if (busy_q) begin
				if (count_q == {`WAIT_CNT_W{1'b0}}) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
				end else if (conv_edge) begin
					count_q <= count_q - {{(`WAIT_CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: conversion_mode_cfg_props.sv
`timescale 1ns/10ps
`default_nettype none
module conversion_mode_cfg_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        start_req,
	input wire logic        stop_req,
	input wire logic        conv_done,
	input wire logic [4:0]  output_rate_code,
	input wire logic [18:0] rate_decisps,
	input wire logic [2:0]  filter_code,
	input wire logic [4:0]  filter_onehot,
	input wire logic [1:0]  op_mode,
	input wire logic        chop_en,
	input wire logic        ac_excite_en,
	input wire logic        ac_four_wire,
	input wire logic        one_shot_select,
	input wire logic [3:0]  start_wait_code,
	input wire logic        wait_active,
	input wire logic        conv_run,
	input wire logic        conv_idle,
	input wire logic        cfg_fault,
	input wire logic [3:0]  aux_pin_link,
	input wire logic [3:0]  aux_pin_dir_input,
	input wire logic [3:0]  aux_pin_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_rate_reset: assert property ($rose(hresetn) |-> output_rate_code == 5'h04 && filter_code == 3'h4)
		else $error("rate or filter field not at reset value");
	chk_ctrl_reset: assert property ($rose(hresetn) |-> op_mode == 2'h0 && !one_shot_select
		&& start_wait_code == 4'h1 && aux_pin_link == 4'h0 && aux_pin_dir_input == 4'h0)
		else $error("control or aux field not at reset value");
	chk_top_rate: assert property ($past(output_rate_code) >= 5'h10 |-> rate_decisps == 19'd400000)
		else $error("top rate code not decoded as 40000");
	chk_rate_max: assert property ($past(output_rate_code) == 5'h0f |-> rate_decisps == 19'd256000)
		else $error("rate code 0f not decoded as 25600");
	chk_filter_decode: assert property ($past(filter_code) <= 3'h4 |-> filter_onehot == (5'h01 << $past(filter_code)))
		else $error("filter decode wrong");
	chk_chop_mode: assert property ($past(op_mode) == 2'h1 |-> chop_en && !ac_excite_en)
		else $error("chop mode decode wrong");
	chk_four_wire: assert property ($past(op_mode) == 2'h3 |-> ac_excite_en && ac_four_wire)
		else $error("four wire mode decode wrong");
	chk_aux_enable: assert property (aux_pin_oe == (aux_pin_dir_input ^ 4'hf))
		else $error("aux output enable not inverse of direction");
	chk_wait_fault: assert property ($past(start_wait_code) == 4'h0 && $past(output_rate_code) >= 5'h0f |-> cfg_fault)
		else $error("zero wait at high rate not flagged");
	chk_start_wait: assert property (conv_idle && start_req |=> wait_active)
		else $error("start did not enter wait");
	chk_oneshot_idle: assert property (conv_run && conv_done && one_shot_select |=> conv_idle)
		else $error("one shot did not return to idle");
	chk_cont_rewait: assert property (conv_run && conv_done && !stop_req && !one_shot_select |=> wait_active)
		else $error("continuous mode did not wait again");
endmodule
bind conversion_mode_cfg conversion_mode_cfg_props props (.hclk(hclk), .hresetn(hresetn), .start_req(start_req),
	.stop_req(stop_req), .conv_done(conv_done), .output_rate_code(output_rate_code), .rate_decisps(rate_decisps),
	.filter_code(filter_code), .filter_onehot(filter_onehot), .op_mode(op_mode), .chop_en(chop_en),
	.ac_excite_en(ac_excite_en), .ac_four_wire(ac_four_wire), .one_shot_select(one_shot_select),
	.start_wait_code(start_wait_code), .wait_active(wait_active), .conv_run(conv_run), .conv_idle(conv_idle),
	.cfg_fault(cfg_fault), .aux_pin_link(aux_pin_link), .aux_pin_dir_input(aux_pin_dir_input), .aux_pin_oe(aux_pin_oe));
`default_nettype wire

// File: conversion_mode_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_mode_defs.vh"
module conversion_mode_cfg_tb;
	logic        hclk, hresetn, hsel, hwrite, conv_clk_pin, start_req, stop_req, conv_done;
	logic [31:0] haddr, hwdata, rd, v;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hreadyout, hresp, rate_is_top, chop_en, ac_excite_en, ac_four_wire, one_shot_select;
	wire         wait_active, conv_run, conv_idle, cfg_fault;
	wire  [31:0] hrdata;
	wire  [18:0] rate_decisps;
	wire  [4:0]  output_rate_code, filter_onehot;
	wire  [3:0]  start_wait_code, aux_pin_link, aux_pin_dir_input, aux_pin_oe;
	wire  [2:0]  filter_code;
	wire  [1:0]  op_mode;
	int          fails, comparisons, seed, cedges;
	int          mdl[3];
	int          rtab[16] = '{25, 50, 100, 166, 200, 500, 600, 1000, 4000, 12000, 24000, 48000, 72000, 144000,
		192000, 256000};
	longint      wns[3] = '{0, 50000, 59000};

	conversion_mode_cfg dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.conv_clk_pin(conv_clk_pin), .start_req(start_req), .stop_req(stop_req), .conv_done(conv_done),
		.output_rate_code(output_rate_code), .rate_decisps(rate_decisps), .rate_is_top(rate_is_top),
		.filter_code(filter_code), .filter_onehot(filter_onehot), .op_mode(op_mode), .chop_en(chop_en),
		.ac_excite_en(ac_excite_en), .ac_four_wire(ac_four_wire), .one_shot_select(one_shot_select),
		.start_wait_code(start_wait_code), .wait_active(wait_active), .conv_run(conv_run), .conv_idle(conv_idle),
		.cfg_fault(cfg_fault), .aux_pin_link(aux_pin_link), .aux_pin_dir_input(aux_pin_dir_input),
		.aux_pin_oe(aux_pin_oe)
	);

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// Converter clock free of any phase relation to the bus clock
	initial begin
		conv_clk_pin = 1'b0;
		forever #5.3 conv_clk_pin = ~conv_clk_pin;
	end
	always @(posedge conv_clk_pin) cedges++;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 50) chk("hreadyout", 1, 0);
	endtask

	task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		htrans <= 2'b10;
		haddr <= {24'h0, idx, 2'b00};
		hwrite <= wr;
		rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask

	// Write with random upper bits; the model keeps only mapped bytes
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		r = $random(seed);
		ahb(1'b1, idx, {r[31:8], d});
		if (idx >= 2 && idx <= 4) mdl[idx - 2] = (idx == `IDX_CONV_CTRL) ? d & 8'h7f : d;
	endtask

	task automatic rdchk(input logic [5:0] idx);
		ahb(1'b0, idx, 32'h0);
		chk("register", (idx >= 2 && idx <= 4) ? mdl[idx - 2] : 0, rd);
		chk("hresp", `HRESP_OKAY, hresp);
	endtask

	// One-cycle pulse: 0 start, 1 stop, 2 conversion done
	task automatic pulse(input int which);
		if (which == 0) start_req <= 1'b1;
		else if (which == 1) stop_req <= 1'b1;
		else conv_done <= 1'b1;
		@(posedge hclk);
		start_req <= 1'b0;
		stop_req <= 1'b0;
		conv_done <= 1'b0;
		@(posedge hclk);
	endtask

	task automatic run_wait(input int exp);
		int n, e0;
		n = 0;
		pulse(0);
		e0 = cedges;
		while (wait_active === 1'b1 && n < 20000) begin
			@(posedge hclk);
			n++;
		end
		e0 = cedges - e0;
		chk("wait edges", exp, (e0 - exp <= 3 && exp - e0 <= 3) ? exp : e0);
		chk("conv_run", 1, conv_run);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		chk("watchdog", 0, 1);
		report_and_stop();
	end

	initial begin
		seed = 32'h2989;
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = `HSIZE_WORD;
		hwdata = 32'h0;
		start_req = 1'b0;
		stop_req = 1'b0;
		conv_done = 1'b0;
		mdl = '{8'h24, 8'h01, 8'h00};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 2; i <= 4; i++) rdchk(i[5:0]);
		chk("rate", 200, rate_decisps);
		$display("reset values test done");
		for (int c = 0; c < 32; c++) begin
			wr(`IDX_RATE_FILTER, {c[4:0], c[2:0]});
			rdchk(`IDX_RATE_FILTER);
			chk("rate", c < 16 ? rtab[c] : 400000, rate_decisps);
			chk("filter", c[2:0] < 5 ? 1 << c[2:0] : 0, filter_onehot);
			chk("top", c >= 16, rate_is_top);
			chk("filter fault", c[2:0] > 4, cfg_fault);
		end
		$display("rate and filter test done");
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			wr(`IDX_CONV_CTRL, {v[7], k[1:0], v[4:0]});
			rdchk(`IDX_CONV_CTRL);
			chk("chop", k == 1, chop_en);
			chk("ac", k[1], ac_excite_en);
			chk("ac4", k == 3, ac_four_wire);
			chk("one shot", v[4], one_shot_select);
			chk("wait code", v[3:0], start_wait_code);
		end
		v = $random(seed);
		wr(`IDX_AUX_PIN, v[7:0]);
		rdchk(`IDX_AUX_PIN);
		chk("link", v[7:4], aux_pin_link);
		chk("dir", v[3:0], aux_pin_dir_input);
		chk("oe", v[3:0] ^ 4'hf, aux_pin_oe);
		$display("control and aux test done");
		wr(6'h05, 8'hff);
		rdchk(6'h05);
		wr(6'h3f, 8'hff);
		rdchk(6'h3f);
		rdchk(`IDX_RATE_FILTER);
		$display("unmapped test done");
		wr(`IDX_RATE_FILTER, {`RATE_25600, `FILT_FIR});
		wr(`IDX_CONV_CTRL, 8'h10);
		repeat (2) @(posedge hclk);
		chk("fault", 1, cfg_fault);
		wr(`IDX_RATE_FILTER, {5'h0e, `FILT_FIR});
		repeat (2) @(posedge hclk);
		chk("fault", 0, cfg_fault);
		for (int w = 0; w < 3; w++) begin
			wr(`IDX_CONV_CTRL, {4'h1, w[3:0]});
			run_wait(int'((wns[w] * 64'd7372800 + 64'd999999999) / 64'd1000000000));
			pulse(2);
			chk("idle", 1, conv_idle);
		end
		wr(`IDX_CONV_CTRL, 8'h01);
		run_wait(369);
		ahb(1'b0, `IDX_SEQ_STATUS, 32'h0);
		chk("status", 32'h2, rd);
		pulse(2);
		chk("rewait", 1, wait_active);
		pulse(1);
		chk("idle", 1, conv_idle);
		$display("start wait test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
